// file: timer_consts.vh
// Offsets, field positions and reset values of the 16-bit timer block
// ----------------------------------------------------------------------
// How it works
// - Timer count is 16 bits, advancing once per prescale value plus one clocks.
// - Prescale count equal to prescale value: next clock bumps count, clears prescaler.
// - Prescale count is a 16-bit counter, readable and writable over the bus.
// - Timer control lets software disable the count or hold it in reset.
// - Match control picks, per channel, flag raising and count reset on match.
// - Four match values compare against the count; reset, halt and/or flag.
// - Capture control picks capture edges per input and whether a flag rises.
// - Selected event on capture input 0 copies the count into capture value 0.
// - Selected event on capture input 1 copies the count into capture value 1.
// - External match control governs match actions and the match output pins.
// - Count mode control picks timer mode or counting edges of a chosen input.
// - PWM enable turns on PWM operation per external match output pin.
// - Interrupt flags hold four match and two capture flags, readable by software.
// - A flag reads one while raised and not cleared, zero otherwise.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Match flags at bits 0-3, capture 0 at 4, capture 1 at 5 here.
// - Sibling places capture 1 flag at bit 6; the position is a parameter.
// - Reset values apply to implemented bits; reserved bits read as zero.
// - Control bit 0 enables counters; bit 1 holds both counters at zero.
// - The count wraps from its maximum to zero without raising any flag.
// - A match with stop enabled halts counters and clears the enable bit.
// ----------------------------------------------------------------------
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_INT_FLAGS 12'h000
`define OFS_TIMER_CTRL 12'h004
`define OFS_TIMER_COUNT 12'h008
`define OFS_PRESCALE_VAL 12'h00C
`define OFS_PRESCALE_CNT 12'h010
`define OFS_MATCH_CTRL 12'h014
`define OFS_MATCH_VAL0 12'h018
`define OFS_MATCH_VAL1 12'h01C
`define OFS_MATCH_VAL2 12'h020
`define OFS_MATCH_VAL3 12'h024
`define OFS_CAPTURE_CTRL 12'h028
`define OFS_CAPTURE_VAL0 12'h02C
`define OFS_CAPTURE_VAL1 12'h030
`define OFS_EXT_MATCH 12'h03C
`define OFS_COUNT_MODE 12'h070
`define OFS_PWM_EN 12'h074

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET_BIT 1
`define CAP1_FLAG_BIT_DEFAULT 5
`define MODE_TIMER 2'h0
`define ACT_NONE 2'h0
`define ACT_CLEAR 2'h1
`define ACT_SET 2'h2
`define ACT_TOGGLE 2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_WORD16 16'h0000
`define RST_CTRL 2'h0
`define RST_FLAGS 6'h00
`define RST_MATCH_CTRL 12'h000
`define RST_CAPTURE_CTRL 6'h00
`define RST_EXT_ACTIONS 8'h00
`define RST_COUNT_MODE 4'h0
`define RST_PWM 2'h0

`endif

// file: edge_detect.v
// Pin synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module edge_detect (
  input wire pclk,
  input wire presetn,
  input wire pin,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  // Two flops against metastability, a third remembers the old level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are seen only on settled levels
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// file: match_pin.v
// One external match output state bit with its action and PWM mode
`timescale 1ns/100ps
`include "timer_consts.vh"
module match_pin (
  input wire pclk,
  input wire presetn,
  input wire hit,
  input wire [1:0] action,
  input wire pwm_mode,
  input wire count_ge,
  input wire wr_en,
  input wire wr_val,
  output reg state_q
);
  reg state_d;

  // PWM follows the compare; otherwise a hit beats a software write
  always @* begin
    state_d = state_q;
    if (pwm_mode) begin
      state_d = count_ge;
    end else if (hit) begin
      case (action)
        `ACT_CLEAR: state_d = 1'b0;
        `ACT_SET: state_d = 1'b1;
        `ACT_TOGGLE: state_d = ~state_q;
        default: state_d = state_q;
      endcase
    end else if (wr_en) begin
      state_d = wr_val;
    end
  end

  // State register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end
endmodule

// file: timer16.v
// Sixteen-bit timer/counter with match, capture and APB register file
`timescale 1ns/100ps
`include "timer_consts.vh"
module timer16 #(
  parameter CAP1_BIT = `CAP1_FLAG_BIT_DEFAULT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire capture_input_0,
  input wire capture_input_1,
  output wire [1:0] match_outputs
);

  // --------------------------------------------------------------------
  // Edge selection shared by capture and counter mode
  // --------------------------------------------------------------------
  // Bit 0 picks rising, bit 1 falling, both picks either edge
  function edge_sel;
    input [1:0] sel;
    input r;
    input f;
    begin
      edge_sel = (sel[0] & r) | (sel[1] & f);
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [5:0] flags_q;
  reg [5:0] flags_d;
  reg [1:0] timer_control_q;
  reg [1:0] timer_control_d;
  reg [15:0] timer_count_q;
  reg [15:0] timer_count_d;
  reg [15:0] prescale_value_q;
  reg [15:0] prescale_count_q;
  reg [15:0] prescale_count_d;
  reg [11:0] match_control_q;
  reg [15:0] match_value_q [0:3];
  reg [5:0] capture_control_q;
  reg [15:0] capture_value_0_q;
  reg [15:0] capture_value_1_q;
  reg [7:0] ext_actions_q;
  reg [3:0] count_mode_control_q;
  reg [1:0] pwm_enable_q;
  reg [31:0] rdata_d;

  wire [1:0] rise;
  wire [1:0] fall;
  wire [3:0] match_state;
  wire [3:0] match_hit;
  wire [3:0] hit_int;
  wire [3:0] hit_reset;
  wire [3:0] hit_stop;
  wire [3:0] count_ge;
  wire [3:0] pwm_vec;
  wire [5:0] flag_set;
  wire [5:0] flag_clr;
  wire [31:0] flags_word;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  // Zero-wait slave: pready rises for the access cycle after setup
  wire setup_ph = psel & ~penable;
  wire wr = psel & penable & pwrite & pready;
  wire wr_flags = wr & (paddr == `OFS_INT_FLAGS);
  wire wr_ctrl = wr & (paddr == `OFS_TIMER_CTRL);
  wire wr_count = wr & (paddr == `OFS_TIMER_COUNT);
  wire wr_pval = wr & (paddr == `OFS_PRESCALE_VAL);
  wire wr_pcnt = wr & (paddr == `OFS_PRESCALE_CNT);
  wire wr_mctrl = wr & (paddr == `OFS_MATCH_CTRL);
  wire wr_cctrl = wr & (paddr == `OFS_CAPTURE_CTRL);
  wire wr_ext = wr & (paddr == `OFS_EXT_MATCH);
  wire wr_mode = wr & (paddr == `OFS_COUNT_MODE);
  wire wr_pwm = wr & (paddr == `OFS_PWM_EN);

  // --------------------------------------------------------------------
  // Capture pins
  // --------------------------------------------------------------------
  edge_detect u_cap0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_input_0),
    .rise(rise[0]),
    .fall(fall[0])
  );

  edge_detect u_cap1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_input_1),
    .rise(rise[1]),
    .fall(fall[1])
  );

  // Capture triggers per input, edges picked by capture control
  wire cap0_ev = edge_sel(capture_control_q[1:0], rise[0], fall[0]);
  wire cap1_ev = edge_sel(capture_control_q[4:3], rise[1], fall[1]);

  // --------------------------------------------------------------------
  // Count sources and prescaler
  // --------------------------------------------------------------------
  // Counter mode counts edges of the chosen capture input
  wire in_sel = count_mode_control_q[2];
  wire src_rise = in_sel ? rise[1] : rise[0];
  wire src_fall = in_sel ? fall[1] : fall[0];
  wire timer_mode = (count_mode_control_q[1:0] == `MODE_TIMER);
  wire count_ev = timer_mode |
                  edge_sel(count_mode_control_q[1:0], src_rise,
                           src_fall);
  wire run = timer_control_q[`CTRL_ENABLE_BIT] &
             ~timer_control_q[`CTRL_RESET_BIT];
  wire terminal = (prescale_count_q == prescale_value_q);
  wire tick = run & count_ev & terminal;

  // --------------------------------------------------------------------
  // Match compare
  // --------------------------------------------------------------------
  // A match counts when the count holds the value at a tick, so a reset
  // on match gives a period of match value plus one counts
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_match
      assign match_hit[i] = tick &
                            (timer_count_q == match_value_q[i]);
      assign hit_int[i] = match_hit[i] & match_control_q[3*i];
      assign hit_reset[i] = match_hit[i] &
                            match_control_q[3*i+1];
      assign hit_stop[i] = match_hit[i] & match_control_q[3*i+2];
      assign count_ge[i] = (timer_count_q >= match_value_q[i]);

      match_pin u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .hit(match_hit[i]),
        .action(ext_actions_q[2*i+1:2*i]),
        .pwm_mode(pwm_vec[i]),
        .count_ge(count_ge[i]),
        .wr_en(wr_ext),
        .wr_val(pwdata[i]),
        .state_q(match_state[i])
      );
    end
  endgenerate

  // Only the first two channels have pins and hence PWM
  assign pwm_vec = {2'b00, pwm_enable_q};
  assign match_outputs = match_state[1:0];

  // --------------------------------------------------------------------
  // Timer and prescale counters
  // --------------------------------------------------------------------
  // Held reset wins, then software writes, then match reset, then tick
  always @* begin
    timer_count_d = timer_count_q;
    prescale_count_d = prescale_count_q;
    if (timer_control_q[`CTRL_RESET_BIT]) begin
      timer_count_d = `RST_WORD16;
      prescale_count_d = `RST_WORD16;
    end else begin
      if (wr_count) begin
        timer_count_d = pwdata[15:0];
      end else if (|hit_reset) begin
        timer_count_d = `RST_WORD16;
      end else if (tick) begin
        // Plain 16-bit add wraps to zero, no flag on the wrap
        timer_count_d = timer_count_q + 16'h0001;
      end
      if (wr_pcnt) begin
        prescale_count_d = pwdata[15:0];
      end else if (run & count_ev) begin
        if (terminal) begin
          prescale_count_d = `RST_WORD16;
        end else begin
          prescale_count_d = prescale_count_q + 16'h0001;
        end
      end
    end
  end

  // Stop on match overrides a write to the enable in the same cycle
  always @* begin
    timer_control_d = timer_control_q;
    if (wr_ctrl) begin
      timer_control_d = pwdata[1:0];
    end
    if (|hit_stop) begin
      timer_control_d[`CTRL_ENABLE_BIT] = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------
  // Capture 1 flag moves with CAP1_BIT; the other spare bit reads zero
  assign flag_set = {cap1_ev & capture_control_q[5],
                     cap0_ev & capture_control_q[2],
                     hit_int};
  assign flag_clr = wr_flags ? {pwdata[CAP1_BIT], pwdata[4:0]} :
                    6'h00;
  assign flags_word = {{27{1'b0}}, flags_q[4:0]} |
                      ({{31{1'b0}}, flags_q[5]} << CAP1_BIT);

  // Set wins over clear so an event in the clearing cycle survives
  always @* begin
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // Narrow fields sit low, upper bits and holes read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `OFS_INT_FLAGS: rdata_d = flags_word;
      `OFS_TIMER_CTRL: rdata_d = {30'h00000000, timer_control_q};
      `OFS_TIMER_COUNT: rdata_d = {16'h0000, timer_count_q};
      `OFS_PRESCALE_VAL: rdata_d = {16'h0000, prescale_value_q};
      `OFS_PRESCALE_CNT: rdata_d = {16'h0000, prescale_count_q};
      `OFS_MATCH_CTRL: rdata_d = {20'h00000, match_control_q};
      `OFS_MATCH_VAL0: rdata_d = {16'h0000, match_value_q[0]};
      `OFS_MATCH_VAL1: rdata_d = {16'h0000, match_value_q[1]};
      `OFS_MATCH_VAL2: rdata_d = {16'h0000, match_value_q[2]};
      `OFS_MATCH_VAL3: rdata_d = {16'h0000, match_value_q[3]};
      `OFS_CAPTURE_CTRL: rdata_d = {26'h0000000, capture_control_q};
      `OFS_CAPTURE_VAL0: rdata_d = {16'h0000, capture_value_0_q};
      `OFS_CAPTURE_VAL1: rdata_d = {16'h0000, capture_value_1_q};
      `OFS_EXT_MATCH: rdata_d = {20'h00000, ext_actions_q, match_state};
      `OFS_COUNT_MODE: rdata_d = {28'h0000000, count_mode_control_q};
      `OFS_PWM_EN: rdata_d = {30'h00000000, pwm_enable_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------
  // Bus response registers
  // --------------------------------------------------------------------
  // Read data is latched at the setup edge and held through the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= 1'b0;
      if (setup_ph & ~pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  // --------------------------------------------------------------------
  // Counter and flag registers
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `RST_FLAGS;
      timer_control_q <= `RST_CTRL;
      timer_count_q <= `RST_WORD16;
      prescale_count_q <= `RST_WORD16;
    end else begin
      flags_q <= flags_d;
      timer_control_q <= timer_control_d;
      timer_count_q <= timer_count_d;
      prescale_count_q <= prescale_count_d;
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Writes to unmapped offsets match no strobe and are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_value_q <= `RST_WORD16;
      match_control_q <= `RST_MATCH_CTRL;
      capture_control_q <= `RST_CAPTURE_CTRL;
      ext_actions_q <= `RST_EXT_ACTIONS;
      count_mode_control_q <= `RST_COUNT_MODE;
      pwm_enable_q <= `RST_PWM;
    end else begin
      if (wr_pval) begin
        prescale_value_q <= pwdata[15:0];
      end
      if (wr_mctrl) begin
        match_control_q <= pwdata[11:0];
      end
      if (wr_cctrl) begin
        capture_control_q <= pwdata[5:0];
      end
      if (wr_ext) begin
        ext_actions_q <= pwdata[11:4];
      end
      if (wr_mode) begin
        // Bit 3 is reserved and must read back as zero
        count_mode_control_q <= {1'b0, pwdata[2:0]};
      end
      if (wr_pwm) begin
        pwm_enable_q <= pwdata[1:0];
      end
    end
  end

  // Match values, one word each at consecutive offsets
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_mval
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          match_value_q[i] <= `RST_WORD16;
        end else if (wr & (paddr == `OFS_MATCH_VAL0 + 4 * i)) begin
          match_value_q[i] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Capture registers
  // --------------------------------------------------------------------
  // Read-only to software; captures run whether or not the timer runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_0_q <= `RST_WORD16;
      capture_value_1_q <= `RST_WORD16;
    end else begin
      if (cap0_ev) begin
        capture_value_0_q <= timer_count_q;
      end
      if (cap1_ev) begin
        capture_value_1_q <= timer_count_q;
      end
    end
  end

endmodule

// file: timer16_sva.sv
// Port-level assertions for the 16-bit timer register block
`timescale 1ns/100ps
module timer16_sva #(
  parameter CAP1_BIT = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire capture_input_0,
  input wire capture_input_1,
  input wire [1:0] match_outputs
);
  // ----------------------------------------------------------------
  // Helper decode
  // ----------------------------------------------------------------
  localparam int RSV = (CAP1_BIT == 5) ? 6 : 5;
  wire rd_setup = psel && !penable && !pwrite;
  wire wr_done = psel && penable && pready && pwrite;
  reg [31:0] wd_q;

  // Last committed write data, for the readback check
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wd_q <= 32'h0;
    else if (wr_done)
      wd_q <= pwdata;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_no_slverr: assert property (!pslverr)
    else $error("pslverr raised");
  a_rdata_stable: assert property (!rd_setup |=> $stable(prdata))
    else $error("prdata changed without read setup");
  a_hole_zero: assert property (rd_setup && paddr == 12'h034 |=>
    prdata == 32'h0)
    else $error("reserved offset read nonzero");
  a_flag_reserved: assert property (
    rd_setup && paddr == 12'h000 |=>
    prdata[31:7] == 25'h0 && !prdata[RSV])
    else $error("reserved flag bits read nonzero");
  a_count_width: assert property (rd_setup && paddr == 12'h008 |=>
    prdata[31:16] == 16'h0)
    else $error("count reads wider than 16 bits");
  a_match_readback: assert property (wr_done && paddr == 12'h018 ##1
    rd_setup && paddr == 12'h018 |=> prdata[15:0] == wd_q[15:0])
    else $error("match value 0 readback differs");
endmodule

bind timer16 timer16_sva #(.CAP1_BIT(CAP1_BIT)) i_timer16_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .capture_input_0, .capture_input_1, .match_outputs
);

// file: capture_pin_model.sv
// Far-side model driving the two capture pins
`timescale 1ns/100ps
module capture_pin_model (
  input wire pclk,
  input wire [1:0] level_req,
  output reg capture_input_0,
  output reg capture_input_1
);
  // Pins idle low until a level is requested
  initial begin
    capture_input_0 = 1'b0;
    capture_input_1 = 1'b0;
  end

  // Pins move just after an edge, like a synchronous source
  always @(posedge pclk) begin
    capture_input_0 <= level_req[0];
    capture_input_1 <= level_req[1];
  end
endmodule

// file: timer16_tb.sv
// Self-checking testbench of the 16-bit timer register block
`timescale 1ns/100ps
module timer16_tb;
  localparam CAP1 = 5;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, cap0, cap1;
  wire [1:0] match_outputs;
  logic [1:0] pin_req;
  int bad_count, comparisons, i;
  logic [11:0] all_a [18] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
    12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030,
    12'h03C, 12'h070, 12'h074, 12'h034, 12'h040};
  logic [11:0] rw_a [12] = '{12'h018, 12'h01C, 12'h020, 12'h024, 12'h00C,
    12'h008, 12'h010, 12'h014, 12'h028, 12'h03C, 12'h070, 12'h074};
  logic [31:0] rw_m [12] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFF, 32'h3F, 32'hFFF, 32'h7, 32'h3};

  timer16 #(.CAP1_BIT(CAP1)) i_timer16 (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_0(cap0),
    .capture_input_1(cap1), .match_outputs(match_outputs));

  capture_pin_model i_capture_pin_model (.pclk(pclk), .level_req(pin_req),
    .capture_input_0(cap0), .capture_input_1(cap1));

  // ----------------------------------------------------------------
  // Clock and run control
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Generous bound: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; the caller releases or starts the next setup at once
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    r = prdata;
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
    idle();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    idle();
    chk(q, e);
  endtask

  // Write then read back-to-back, with no idle cycle between
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] e);
    apb(1'b1, a, d, q);
    apb(1'b0, a, 32'h0, q);
    idle();
    chk(q, e);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_req = 2'b00;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 18; i++) rd(all_a[i], 32'h0);
    // Reserved bits drop, capture values and holes ignore writes
    for (i = 0; i < 12; i++) begin
      wr_rd(rw_a[i], 32'hFFFFFFFF, rw_m[i]);
      if (rw_a[i] == 12'h03C) chk({30'h0, match_outputs}, 32'h3);
    end
    for (i = 0; i < 12; i++) wr(rw_a[i], 32'h0);
    wr_rd(12'h02C, 32'hFFFFFFFF, 32'h0);
    wr_rd(12'h030, 32'hFFFFFFFF, 32'h0);
    wr_rd(12'h034, 32'hFFFFFFFF, 32'h0);
    // Eighteen enabled clocks with divide-by-four prescale
    wr(12'h00C, 32'h3);
    wr(12'h004, 32'h1);
    repeat (15) @(posedge pclk);
    wr(12'h004, 32'h0);
    rd(12'h008, 32'h4);
    rd(12'h010, 32'h2);
    wr_rd(12'h004, 32'h3, 32'h3);
    rd(12'h008, 32'h0);
    rd(12'h010, 32'h0);
    // A held counter reset beats a software write of the count
    wr_rd(12'h008, 32'hFFFE, 32'h0);
    // Wrap past the top gives no flag; the held reset drops first
    wr(12'h004, 32'h0);
    wr(12'h00C, 32'h0);
    wr(12'h008, 32'hFFFE);
    wr(12'h004, 32'h1);
    wr(12'h004, 32'h0);
    rd(12'h008, 32'h1);
    rd(12'h000, 32'h0);
    // Stop on match, then write-one-to-clear
    wr(12'h018, 32'h5);
    wr(12'h014, 32'h5);
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h1);
    repeat (20) @(posedge pclk);
    rd(12'h004, 32'h0);
    rd(12'h000, 32'h1);
    wr(12'h000, 32'h0);
    rd(12'h000, 32'h1);
    wr(12'h000, 32'h1);
    rd(12'h000, 32'h0);
    // Reset on match with flag, for every channel
    for (i = 0; i < 4; i++) begin
      wr(12'h018 + 12'(4 * i), 32'h3);
      wr(12'h014, 32'h3 << (3 * i));
      wr(12'h008, 32'h0);
      wr(12'h004, 32'h1);
      repeat (20) @(posedge pclk);
      wr(12'h004, 32'h0);
      apb(1'b0, 12'h008, 32'h0, q);
      idle();
      chk({31'h0, q[15:0] <= 16'h3}, 32'h1);
      rd(12'h000, 32'h1 << i);
      wr(12'h000, 32'h3F);
      wr(12'h014, 32'h0);
    end
    // Rising-edge captures with flags, timer stopped
    wr(12'h028, 32'h2D);
    wr(12'h008, 32'h100);
    pin_req[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h02C, 32'h100);
    rd(12'h000, 32'h10);
    wr(12'h008, 32'h200);
    pin_req[1] <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h030, 32'h200);
    rd(12'h000, 32'h10 | (32'h1 << CAP1));
    wr(12'h000, 32'h3F);
    pin_req <= 2'b00;
    repeat (8) @(posedge pclk);
    rd(12'h000, 32'h0);
    // Counter mode: rising edges of input 0, then both edges of input 1
    wr(12'h028, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(12'h070, i ? 32'h7 : 32'h1);
      wr(12'h008, 32'h0);
      wr(12'h004, 32'h1);
      repeat (3) begin
        pin_req[i] <= 1'b1;
        repeat (6) @(posedge pclk);
        pin_req[i] <= 1'b0;
        repeat (6) @(posedge pclk);
      end
      wr(12'h004, 32'h0);
      rd(12'h008, i ? 32'h6 : 32'h3);
    end
    wr(12'h070, 32'h0);
    // Toggle on a channel 0 match; stop on it so it fires only once
    wr(12'h014, 32'h4);
    wr(12'h03C, 32'h30);
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h1);
    repeat (8) @(posedge pclk);
    chk({30'h0, match_outputs}, 32'h1);
    wr(12'h014, 32'h0);
    // PWM output follows count at or above match value 0, a clock late
    wr(12'h03C, 32'h0);
    wr(12'h018, 32'h5);
    wr(12'h074, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, match_outputs[0]}, 32'h0);
    wr(12'h018, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, match_outputs[0]}, 32'h1);
    conclude();
  end
endmodule
